// ---- axis_homing_handshake.sv ----
`timescale 1ns/1ps
`include "axis_homing_params.svh"
module axis_homing_handshake (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire axis_homing_pkg::drive_in_s drive_in,
   output logic drive_run,
   output logic [7:0] home_axis,
   output logic [31:0] home_offset,
   output axis_homing_pkg::run_flags_s flags,
   output logic [15:0] fault_code
);
   import axis_homing_pkg::*;

   logic wr_en, wr_err, rd_err;
   logic [`ADDR_W-1:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data, merged_ctrl, merged_ofs;
   logic [3:0] wr_strb;
   logic [31:0] ctrl_reg, ctrl_next, offset_reg, offset_next;
   logic start_prev_reg, start_prev_next;
   home_state_e state_reg, state_next;
   run_flags_s flags_reg, flags_next;
   logic [15:0] fault_reg, fault_next;
   logic run_reg, run_next;
   logic start, rise, axis_ok;

   axil_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // Byte-lane merge of write data into writable registers
   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign merged_ctrl[i*8 +: 8] = wr_strb[i] ? wr_data[i*8 +: 8] : ctrl_reg[i*8 +: 8];
      assign merged_ofs[i*8 +: 8] = wr_strb[i] ? wr_data[i*8 +: 8] : offset_reg[i*8 +: 8];
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      offset_next = offset_reg;
      wr_err = 1'b0;
      if (wr_addr == `CTRL_OFS) begin
         if (wr_en) ctrl_next = merged_ctrl & `CTRL_MASK;
      end else if (wr_addr == `OFFSET_OFS) begin
         if (wr_en) offset_next = merged_ofs;
      end else if (wr_addr == `STATUS_OFS || wr_addr == `FAULT_OFS) begin
         wr_err = 1'b0;
      end else begin
         wr_err = 1'b1;
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err = 1'b0;
      if (rd_addr == `CTRL_OFS) begin
         rd_data = ctrl_reg;
      end else if (rd_addr == `OFFSET_OFS) begin
         rd_data = offset_reg;
      end else if (rd_addr == `STATUS_OFS) begin
         rd_data = {27'h0000000, flags_reg};
      end else if (rd_addr == `FAULT_OFS) begin
         rd_data = {16'h0000, fault_reg};
      end else begin
         rd_err = 1'b1;
      end
   end

   assign start = ctrl_reg[`START_BIT];
   assign rise = start && !start_prev_reg;

   param_latch u_latch (
      .aclk(aclk),
      .aresetn(aresetn),
      .capture(rise && state_reg == ST_IDLE),
      .axis_in(ctrl_reg[`AXIS_MSB:`AXIS_LSB]),
      .offset_in(offset_reg),
      .axis_reg(home_axis),
      .offset_reg(home_offset),
      .axis_ok_reg(axis_ok)
   );

   always_comb begin
      state_next = state_reg;
      flags_next = flags_reg;
      fault_next = fault_reg;
      start_prev_next = start;
      case (state_reg)
         ST_IDLE: begin
            flags_next = '0;
            if (rise) begin
               state_next = ST_ARM;
               flags_next.busy = 1'b1;
               fault_next = `ERR_NONE;
            end
         end
         ST_ARM: begin
            flags_next.busy = 1'b0;
            if (!drive_in.standstill) begin
               state_next = ST_FAULT;
               flags_next.error = 1'b1;
               fault_next = `ERR_NOT_STANDSTILL;
            end else if (!axis_ok) begin
               state_next = ST_FAULT;
               flags_next.error = 1'b1;
               fault_next = `ERR_BAD_AXIS;
            end else begin
               state_next = ST_RUN;
               flags_next.busy = 1'b1;
               flags_next.active = 1'b1;
            end
         end
         ST_RUN: begin
            if (drive_in.fail) begin
               state_next = ST_FAULT;
               flags_next = '0;
               flags_next.error = 1'b1;
               fault_next = (drive_in.fail_code == `ERR_NONE) ? `ERR_DRIVE
                                                             : drive_in.fail_code;
            end else if (drive_in.preempt) begin
               state_next = ST_ABORT;
               flags_next = '0;
               flags_next.preempted_flag = 1'b1;
            end else if (drive_in.done) begin
               state_next = ST_DONE;
               flags_next = '0;
               flags_next.done = 1'b1;
            end
         end
         ST_DONE, ST_ABORT, ST_FAULT: begin
            // Outcome held while start high, dropped once it is low
            if (!start) begin
               state_next = ST_IDLE;
               flags_next = '0;
            end
         end
         default: begin
            state_next = ST_IDLE;
            flags_next = '0;
         end
      endcase
      run_next = (state_next == ST_RUN);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `CTRL_RST;
         offset_reg <= `OFFSET_RST;
         start_prev_reg <= 1'b0;
         state_reg <= ST_IDLE;
         flags_reg <= '0;
         fault_reg <= `ERR_NONE;
         run_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         offset_reg <= offset_next;
         start_prev_reg <= start_prev_next;
         state_reg <= state_next;
         flags_reg <= flags_next;
         fault_reg <= fault_next;
         run_reg <= run_next;
      end
   end

   assign flags = flags_reg;
   assign fault_code = fault_reg;
   assign drive_run = run_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence start_taken;
      rise && state_reg == ST_IDLE;
   endsequence

   sequence armed_clean;
      start_taken ##1 (drive_in.standstill && axis_ok);
   endsequence

   chk_busy_on_start: assert property (start_taken |=> flags_reg.busy)
      else $error("busy not raised on start edge");
   chk_active_after_busy: assert property (armed_clean |=> flags_reg.active && flags_reg.busy
      && !$past(flags_reg.active, 1))
      else $error("active not one cycle after busy");
   chk_sample_params: assert property (start_taken |=> home_offset == $past(offset_reg)
      && home_axis == $past(ctrl_reg[`AXIS_MSB:`AXIS_LSB]))
      else $error("parameters not sampled on start edge");
   chk_done_hold: assert property (flags_reg.done && start |=> flags_reg.done)
      else $error("done dropped while start high");
   chk_done_pulse: assert property ($rose(flags_reg.done) && !start |=> !flags_reg.done)
      else $error("done longer than one cycle");
   chk_abort_flag: assert property (state_reg == ST_RUN && drive_in.preempt && !drive_in.fail
      |=> flags_reg.preempted_flag ##1 (flags_reg.preempted_flag == $past(start)))
      else $error("aborted flag timing wrong");
   chk_error_until_fall: assert property (flags_reg.error && start |=> flags_reg.error)
      else $error("error dropped before start fell");
   chk_fault_code: assert property (flags_reg.error |-> fault_code != `ERR_NONE)
      else $error("no fault code with error");
   chk_standstill_gate: assert property (state_reg == ST_ARM && !drive_in.standstill
      |=> flags_reg.error && !flags_reg.active && fault_code == `ERR_NOT_STANDSTILL)
      else $error("start accepted off standstill");
   chk_one_outcome: assert property ($onehot0({flags_reg.done, flags_reg.preempted_flag,
      flags_reg.error}))
      else $error("more than one outcome flag");
   chk_outcome_clears: assert property ($rose(flags_reg.done) || $rose(flags_reg.error)
      || $rose(flags_reg.preempted_flag) |-> !flags_reg.busy && !flags_reg.active)
      else $error("busy or active left with outcome");
   chk_done_cause: assert property (state_reg == ST_RUN && drive_in.done && !drive_in.fail
      && !drive_in.preempt |=> flags_reg.done)
      else $error("done missing after completion");
   chk_fail_cause: assert property (state_reg == ST_RUN && drive_in.fail |=> flags_reg.error)
      else $error("error missing after failure");
endmodule

// ---- axis_homing_params.svh ----
// How it works
// - Start rising edge samples axis, offset, runs
// - Signed offset accepted, zero by default
// - Completion flag rises when homing finishes
// - Completion held while start stays high
// - Completion pulses one cycle if start low
// - Busy from start edge until outcome
// - Active while controlling axis, after busy
// - Pre-emption by other command sets aborted
// - Aborted held while start high, else pulse
// - Error on failure or illegal parameter
// - Error held until start falls
// - Sixteen-bit fault code names the cause
// - Aborted output reports early termination
// - Error output reports failure this run
// - Active rises one cycle after busy
// - Start rejected unless axis in standstill
`ifndef AXIS_HOMING_PARAMS_SVH
`define AXIS_HOMING_PARAMS_SVH
`define ADDR_W 8
`define CTRL_OFS 8'h00
`define OFFSET_OFS 8'h04
`define STATUS_OFS 8'h08
`define FAULT_OFS 8'h0C
`define CTRL_RST 32'h0000_0000
`define OFFSET_RST 32'h0000_0000
`define CTRL_MASK 32'h0000_FF01
`define START_BIT 0
`define AXIS_LSB 8
`define AXIS_MSB 15
`define AXIS_MIN 8'h01
`define AXIS_MAX 8'h08
`define ERR_NONE 16'h0000
`define ERR_NOT_STANDSTILL 16'h0001
`define ERR_BAD_AXIS 16'h0002
`define ERR_DRIVE 16'h0003
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- axis_homing_pkg.sv ----
package axis_homing_pkg;
   typedef enum {ST_IDLE, ST_ARM, ST_RUN, ST_DONE, ST_ABORT, ST_FAULT} home_state_e;
   typedef struct packed {
      logic standstill;
      logic done;
      logic fail;
      logic preempt;
      logic [15:0] fail_code;
   } drive_in_s;
   typedef struct packed {
      logic error;
      logic preempted_flag;
      logic active;
      logic busy;
      logic done;
   } run_flags_s;
endpackage

// ---- param_latch.sv ----
`timescale 1ns/1ps
`include "axis_homing_params.svh"
module param_latch (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic capture,
   input wire logic [7:0] axis_in,
   input wire logic [31:0] offset_in,
   output logic [7:0] axis_reg,
   output logic [31:0] offset_reg,
   output logic axis_ok_reg
);
   logic [7:0] axis_next;
   logic [31:0] offset_next;
   logic axis_ok_next;

   always_comb begin
      axis_next = axis_reg;
      offset_next = offset_reg;
      axis_ok_next = axis_ok_reg;
      if (capture) begin
         axis_next = axis_in;
         offset_next = offset_in;
         axis_ok_next = (axis_in >= `AXIS_MIN) && (axis_in <= `AXIS_MAX);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         axis_reg <= 8'h00;
         offset_reg <= `OFFSET_RST;
         axis_ok_reg <= 1'b0;
      end else begin
         axis_reg <= axis_next;
         offset_reg <= offset_next;
         axis_ok_reg <= axis_ok_next;
      end
   end
endmodule

// ---- axil_port.sv ----
`timescale 1ns/1ps
`include "axis_homing_params.svh"
module axil_port (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [`ADDR_W-1:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_err,
   output logic [`ADDR_W-1:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic bvalid_reg, bvalid_next, arready_reg, arready_next;
   logic rvalid_reg, rvalid_next, rd_pend_reg, rd_pend_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next, wdata_reg, wdata_next;
   logic [3:0] wstrb_reg, wstrb_next;
   logic [`ADDR_W-1:0] aw_reg, aw_next, ar_reg, ar_next;

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rresp = rresp_reg;
   assign rdata = rdata_reg;
   // Both halves held and no response pending
   assign wr_en = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_addr = aw_reg;
   assign wr_data = wdata_reg;
   assign wr_strb = wstrb_reg;
   assign rd_addr = ar_reg;

   always_comb begin
      awready_next = awready_reg;
      wready_next = wready_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      aw_next = aw_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      ar_next = ar_reg;
      rd_pend_next = 1'b0;
      if (awready_reg && awvalid) begin
         awready_next = 1'b0;
         aw_next = awaddr;
      end
      if (wready_reg && wvalid) begin
         wready_next = 1'b0;
         wdata_next = wdata;
         wstrb_next = wstrb;
      end
      if (wr_en) begin
         bvalid_next = 1'b1;
         bresp_next = wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
         awready_next = 1'b1;
         wready_next = 1'b1;
      end
      if (arready_reg && arvalid) begin
         arready_next = 1'b0;
         ar_next = araddr;
         rd_pend_next = 1'b1;
      end
      if (rd_pend_reg) begin
         rvalid_next = 1'b1;
         rdata_next = rd_data;
         rresp_next = rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= `RESP_OKAY;
         aw_reg <= '0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         ar_reg <= '0;
         rd_pend_reg <= 1'b0;
      end else begin
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         aw_reg <= aw_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         ar_reg <= ar_next;
         rd_pend_reg <= rd_pend_next;
      end
   end
endmodule

// ---- drive_model.sv ----
`timescale 1ns/1ps
module drive_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic drive_run,
   input wire logic rest_en,
   input wire logic [1:0] mode,
   input wire logic [7:0] delay,
   input wire logic [15:0] code,
   output axis_homing_pkg::drive_in_s drive_in
);
   import axis_homing_pkg::*;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   drive_in_s drive_reg;
   drive_in_s drive_next;
   assign drive_in = drive_reg;
   // One outcome event per run in modes 0 to 2 (none in mode 3), after a chosen number of run cycles
   always_comb begin
      cnt_next = drive_run ? cnt_reg + 8'h01 : 8'h00;
      drive_next = '0;
      drive_next.standstill = rest_en & ~drive_run;
      if (drive_run && cnt_reg == delay) begin
         drive_next.done = (mode == 2'h0);
         drive_next.fail = (mode == 2'h1);
         drive_next.preempt = (mode == 2'h2);
         drive_next.fail_code = (mode == 2'h1) ? code : 16'h0000;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 8'h00;
         drive_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
         drive_reg <= drive_next;
      end
   end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "axis_homing_params.svh"
module tb_top;
   import axis_homing_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, drive_run, rest_en;
   logic [7:0] awaddr, araddr, delay, home_axis;
   logic [31:0] wdata, rdata, home_offset, off_exp, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, mode, rs;
   logic [15:0] fault_code, code;
   drive_in_s drive_in;
   run_flags_s flags;
   int bad_count, n_compared, cycles;

   axis_homing_handshake dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .drive_in(drive_in), .drive_run(drive_run), .home_axis(home_axis),
      .home_offset(home_offset), .flags(flags), .fault_code(fault_code));
   drive_model far_end (.aclk(aclk), .aresetn(aresetn), .drive_run(drive_run),
      .rest_en(rest_en), .mode(mode), .delay(delay), .code(code), .drive_in(drive_in));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_flags(input run_flags_s got, input logic [4:0] exp);
      cmp_word({27'h0, got}, {27'h0, exp});
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask

   // Flag codes: 01 done, 02 busy, 04 active, 08 preempted, 10 error
   task automatic run_case(input logic [7:0] ax, input logic keep, input logic [1:0] md,
         input logic [15:0] fc, input logic [4:0] nxt, input logic [4:0] fin,
         input logic [15:0] ecode);
      int i;
      mode <= md;
      code <= fc;
      delay <= keep ? 8'h04 : 8'h14;
      axi_write(`CTRL_OFS, {16'h0000, ax, 8'h01}, rs);
      i = 0;
      do begin
         @(posedge aclk);
         i++;
      end while (flags.busy !== 1'b1 && i < 8);
      cmp_flags(flags, 5'h02);
      cmp_word({24'h0, home_axis}, {24'h0, ax});
      cmp_word(home_offset, off_exp);
      @(posedge aclk);
      cmp_flags(flags, nxt);
      cmp_word({31'h0, drive_run}, {31'h0, nxt[2]});
      if (!keep) axi_write(`CTRL_OFS, {16'h0000, ax, 8'h00}, rs);
      i = 0;
      while (flags[2:1] !== 2'b00 && i < 40) begin
         @(posedge aclk);
         i++;
      end
      cmp_flags(flags, fin);
      if (fin[4]) cmp_word({16'h0, fault_code}, {16'h0, ecode});
      if (keep) begin
         repeat (3) @(posedge aclk);
         cmp_flags(flags, fin);
         axi_write(`CTRL_OFS, {16'h0000, ax, 8'h00}, rs);
         i = 0;
         while (flags !== 5'h00 && i < 4) begin
            @(posedge aclk);
            i++;
         end
      end else begin
         @(posedge aclk);
      end
      cmp_flags(flags, 5'h00);
   endtask

   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      wstrb = 4'hF;
      rest_en = 1'b1;
      mode = 2'h0;
      delay = 8'h04;
      code = 16'h0000;
      off_exp = 32'h0000_0000;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      cmp_flags(flags, 5'h00);
      cmp_word({16'h0, fault_code}, 32'h0000_0000);
      axi_read(`OFFSET_OFS, rd, rs);
      cmp_word(rd, `OFFSET_RST);
      axi_read(8'h10, rd, rs);
      cmp_word({30'h0, rs}, {30'h0, `RESP_SLVERR});
      cmp_word(rd, 32'h0000_0000);
      axi_write(8'h10, 32'hFFFF_FFFF, rs);
      cmp_word({30'h0, rs}, {30'h0, `RESP_SLVERR});
      axi_write(`STATUS_OFS, 32'hFFFF_FFFF, rs);
      cmp_word({30'h0, rs}, {30'h0, `RESP_OKAY});
      axi_read(`STATUS_OFS, rd, rs);
      cmp_word(rd, 32'h0000_0000);
      axi_write(`CTRL_OFS, 32'hFFFF_00FE, rs);
      axi_read(`CTRL_OFS, rd, rs);
      cmp_word(rd, 32'h0000_0000);
      run_case(8'h01, 1'b1, 2'h0, 16'h0000, 5'h06, 5'h01, 16'h0000);
      off_exp = 32'hFFFF_FFF1;
      axi_write(`OFFSET_OFS, off_exp, rs);
      cmp_word({30'h0, rs}, {30'h0, `RESP_OKAY});
      axi_read(`OFFSET_OFS, rd, rs);
      cmp_word(rd, off_exp);
      cmp_word({30'h0, rs}, {30'h0, `RESP_OKAY});
      run_case(8'h08, 1'b0, 2'h0, 16'h0000, 5'h06, 5'h01, 16'h0000);
      run_case(8'h02, 1'b1, 2'h2, 16'h0000, 5'h06, 5'h08, 16'h0000);
      run_case(8'h03, 1'b0, 2'h2, 16'h0000, 5'h06, 5'h08, 16'h0000);
      run_case(8'h04, 1'b1, 2'h1, 16'h00A5, 5'h06, 5'h10, 16'h00A5);
      run_case(8'h05, 1'b1, 2'h1, 16'h0000, 5'h06, 5'h10, `ERR_DRIVE);
      axi_read(`FAULT_OFS, rd, rs);
      cmp_word(rd, {16'h0, `ERR_DRIVE});
      run_case(8'h00, 1'b1, 2'h0, 16'h0000, 5'h10, 5'h10, `ERR_BAD_AXIS);
      run_case(8'h09, 1'b1, 2'h0, 16'h0000, 5'h10, 5'h10, `ERR_BAD_AXIS);
      rest_en <= 1'b0;
      run_case(8'h01, 1'b1, 2'h0, 16'h0000, 5'h10, 5'h10, `ERR_NOT_STANDSTILL);
      run_case(8'h00, 1'b1, 2'h0, 16'h0000, 5'h10, 5'h10, `ERR_NOT_STANDSTILL);
      summarize();
   end
endmodule
